/* File: csel_pkg.sv */
package csel_pkg;

  localparam int unsigned ADDR_W = 2;
  localparam int unsigned DATA_W = 8;

  // Register offsets
  localparam logic [ADDR_W-1:0] OSC_CONTROL_OFS  = 2'h0;
  localparam logic [ADDR_W-1:0] OSC_CONTROL2_OFS = 2'h1;
  localparam logic [ADDR_W-1:0] OSC_TUNING_OFS   = 2'h2;

  // Field positions
  localparam int unsigned SEL_LSB      = 0;
  localparam int unsigned HF_STB_BIT   = 2;
  localparam int unsigned STARTUP_BIT  = 3;
  localparam int unsigned FREQ_LSB     = 4;
  localparam int unsigned LF_STB_BIT   = 0;
  localparam int unsigned MF_STB_BIT   = 1;
  localparam int unsigned PRI_ON_BIT   = 2;
  localparam int unsigned SEC_EN_BIT   = 3;
  localparam int unsigned MF_SEL_BIT   = 4;
  localparam int unsigned SEC_RUN_BIT  = 6;
  localparam int unsigned PLL_LOCK_BIT = 7;
  localparam int unsigned TUNE_LSB     = 0;
  localparam int unsigned PLL_EN_BIT   = 6;
  localparam int unsigned LF_SRC_BIT   = 7;

  // Values after reset
  localparam logic [1:0] SEL_RST    = 2'h0;
  localparam logic [2:0] FREQ_RST   = 3'h3;
  localparam logic       PRI_ON_RST = 1'b1;

  // Frequency field codes
  localparam logic [2:0] FREQ_16M  = 3'h7;
  localparam logic [2:0] FREQ_8M   = 3'h6;
  localparam logic [2:0] FREQ_4M   = 3'h5;
  localparam logic [2:0] FREQ_2M   = 3'h4;
  localparam logic [2:0] FREQ_1M   = 3'h3;
  localparam logic [2:0] FREQ_500K = 3'h2;
  localparam logic [2:0] FREQ_250K = 3'h1;
  localparam logic [2:0] FREQ_31K  = 3'h0;

  // Primary config codes that route the internal block
  localparam logic [3:0] CFG_INT_A = 4'h8;
  localparam logic [3:0] CFG_INT_B = 4'h9;

  // Postscaler and medium divider depths
  localparam int unsigned HF_DIV_W = 9;
  localparam int unsigned MF_DIV_W = 4;

  typedef enum logic [1:0] {SRC_PRI, SRC_SEC, SRC_INT} csel_src_e;

  typedef struct packed {
    logic primary;
    logic pll;
    logic secondary;
    logic hf;
    logic mf;
    logic lf;
  } csel_ticks_s;

  typedef struct packed {
    logic startup_done;
    logic hf_stable;
    logic mf_stable;
    logic lf_stable;
    logic sec_running;
    logic pll_locked;
  } csel_status_s;

endpackage : csel_pkg

/* File: csel_top.sv */
// The register addresses and the plain strobed port were decided locally.
module csel_top
(
  input  wire logic                           sys_clk_i,
  input  wire logic                           rst_i,
  input  wire logic [csel_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [csel_pkg::DATA_W-1:0]    wr_data_i,
  input  wire logic                           wr_i,
  input  wire logic                           rd_i,
  output logic      [csel_pkg::DATA_W-1:0]    rd_data_o,
  input  wire logic [3:0]                     primary_clk_config_i,
  input  wire csel_pkg::csel_ticks_s          ticks_i,
  input  wire csel_pkg::csel_status_s         status_i,
  output logic                                sys_tick_o,
  output logic                                int_tick_o,
  output logic                                wdt_tick_o,
  output logic [5:0]                          osc_tune_o,
  output logic                                pll_enable_o,
  output logic                                primary_osc_off_o,
  output logic                                secondary_osc_enable_o
);
  import csel_pkg::*;

  typedef enum logic [1:0] {SW_RUN, SW_DRAIN, SW_ARM} csel_sw_e;

  logic [1:0]          sys_clk_select_q;
  logic [2:0]          int_freq_select_q;
  logic                medium_osc_select_q;
  logic                lowfreq_src_select_q;
  logic [5:0]          osc_tune_field_q;
  logic                pll_enable_q;
  logic                primary_on_q;
  logic                secondary_osc_enable_q;
  logic [DATA_W-1:0]   rd_data_q;
  logic [HF_DIV_W-1:0] hf_div_q;
  logic [MF_DIV_W-1:0] mf_div_q;
  logic [HF_DIV_W:0]   post_w;
  logic                int_sel_w;
  logic                int_tick_q;
  logic                wdt_tick_q;
  logic                sys_tick_q;
  logic                prim_off_q;
  logic                pri_tick_w;
  csel_src_e           target_w;
  csel_src_e           cur_src_q;
  csel_sw_e            sw_q;
  logic                cur_tick_w;
  logic                tgt_tick_w;
  logic                wr_ctrl_w;
  logic                wr_ctrl2_w;
  logic                wr_tune_w;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  assign wr_ctrl_w  = wr_i && (addr_i == OSC_CONTROL_OFS);
  assign wr_ctrl2_w = wr_i && (addr_i == OSC_CONTROL2_OFS);
  assign wr_tune_w  = wr_i && (addr_i == OSC_TUNING_OFS);

  //////////////////////////////////////////////////////////////////////////
  // Control registers

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      sys_clk_select_q  <= SEL_RST;
      int_freq_select_q <= FREQ_RST;
    end
    else if (wr_ctrl_w)
    begin
      sys_clk_select_q  <= wr_data_i[SEL_LSB +: 2];
      int_freq_select_q <= wr_data_i[FREQ_LSB +: 3];
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      medium_osc_select_q    <= 1'b0;
      secondary_osc_enable_q <= 1'b0;
      primary_on_q           <= PRI_ON_RST;
    end
    else if (wr_ctrl2_w)
    begin
      medium_osc_select_q    <= wr_data_i[MF_SEL_BIT];
      secondary_osc_enable_q <= wr_data_i[SEC_EN_BIT];
      primary_on_q           <= wr_data_i[PRI_ON_BIT];
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      lowfreq_src_select_q <= 1'b0;
      pll_enable_q         <= 1'b0;
      osc_tune_field_q     <= 6'h00;
    end
    else if (wr_tune_w)
    begin
      lowfreq_src_select_q <= wr_data_i[LF_SRC_BIT];
      pll_enable_q         <= wr_data_i[PLL_EN_BIT];
      osc_tune_field_q     <= wr_data_i[TUNE_LSB +: 6];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Read port, data valid only the cycle after the strobe

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      rd_data_q <= 8'h00;
    end
    else
    begin
      rd_data_q <= 8'h00;
      if (rd_i)
      begin
        unique case (addr_i)
          OSC_CONTROL_OFS:
          begin
            rd_data_q[SEL_LSB +: 2]   <= sys_clk_select_q;
            rd_data_q[HF_STB_BIT]     <= status_i.hf_stable;
            rd_data_q[STARTUP_BIT]    <= status_i.startup_done;
            rd_data_q[FREQ_LSB +: 3]  <= int_freq_select_q;
          end
          OSC_CONTROL2_OFS:
          begin
            rd_data_q[LF_STB_BIT]     <= status_i.lf_stable;
            rd_data_q[MF_STB_BIT]     <= status_i.mf_stable;
            rd_data_q[PRI_ON_BIT]     <= primary_on_q;
            rd_data_q[SEC_EN_BIT]     <= secondary_osc_enable_q;
            rd_data_q[MF_SEL_BIT]     <= medium_osc_select_q;
            rd_data_q[SEC_RUN_BIT]    <= status_i.sec_running;
            rd_data_q[PLL_LOCK_BIT]   <= status_i.pll_locked;
          end
          OSC_TUNING_OFS:
          begin
            rd_data_q[TUNE_LSB +: 6]  <= osc_tune_field_q;
            rd_data_q[PLL_EN_BIT]     <= pll_enable_q;
            rd_data_q[LF_SRC_BIT]     <= lowfreq_src_select_q;
          end
          default:
          begin
            rd_data_q <= 8'h00;
          end
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // High source postscaler and medium divider

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      hf_div_q <= 9'h000;
    end
    else if (ticks_i.hf)
    begin
      hf_div_q <= hf_div_q + 9'h001;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      mf_div_q <= 4'h0;
    end
    else if (ticks_i.mf)
    begin
      mf_div_q <= mf_div_q + 4'h1;
    end
  end

  // Bit k is the high source divided by two to the k
  assign post_w[0] = ticks_i.hf;
  for (genvar k = 1; k <= HF_DIV_W; k++)
  begin : g_post
    assign post_w[k] = ticks_i.hf && (&hf_div_q[k-1:0]);
  end

  //////////////////////////////////////////////////////////////////////////
  // Internal block output select, no extra latency on a change

  always_comb
  begin
    int_sel_w = 1'b0;
    unique case (int_freq_select_q)
      FREQ_16M:  int_sel_w = post_w[0];
      FREQ_8M:   int_sel_w = post_w[1];
      FREQ_4M:   int_sel_w = post_w[2];
      FREQ_2M:   int_sel_w = post_w[3];
      FREQ_1M:   int_sel_w = post_w[4];
      FREQ_500K: int_sel_w = medium_osc_select_q ? ticks_i.mf
                                                 : post_w[5];
      FREQ_250K: int_sel_w = medium_osc_select_q
                             ? (ticks_i.mf && mf_div_q[0]) : post_w[6];
      FREQ_31K:
      begin
        if (!lowfreq_src_select_q)
          int_sel_w = ticks_i.lf;
        else if (medium_osc_select_q)
          int_sel_w = ticks_i.mf && (&mf_div_q);
        else
          int_sel_w = post_w[HF_DIV_W];
      end
    endcase
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      int_tick_q <= 1'b0;
      wdt_tick_q <= 1'b0;
    end
    else
    begin
      int_tick_q <= int_sel_w;
      wdt_tick_q <= ticks_i.lf;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Source choice and glitch-free handover

  assign pri_tick_w = pll_enable_q ? ticks_i.pll : ticks_i.primary;

  always_comb
  begin
    unique case (sys_clk_select_q)
      2'h0:    target_w = SRC_PRI;
      2'h1:    target_w = SRC_SEC;
      default: target_w = SRC_INT;
    endcase
  end

  function automatic logic src_tick(input csel_src_e s,
                                    input logic [3:0] cfg,
                                    input logic pri,
                                    input logic sec,
                                    input logic int_t);
    logic r;
    r = int_t;
    if (s == SRC_SEC)
      r = sec;
    else if (s == SRC_PRI && cfg != CFG_INT_A && cfg != CFG_INT_B)
      r = pri;
    return r;
  endfunction : src_tick

  assign cur_tick_w = src_tick(cur_src_q, primary_clk_config_i,
                               pri_tick_w, ticks_i.secondary, int_sel_w);
  assign tgt_tick_w = src_tick(target_w, primary_clk_config_i,
                               pri_tick_w, ticks_i.secondary, int_sel_w);

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      sw_q      <= SW_RUN;
      cur_src_q <= SRC_PRI;
    end
    else
    begin
      unique case (sw_q)
        SW_RUN:
          if (target_w != cur_src_q)
            sw_q <= SW_DRAIN;
        SW_DRAIN:
          if (cur_tick_w)
            sw_q <= SW_ARM;
        SW_ARM:
          if (tgt_tick_w)
          begin
            sw_q      <= SW_RUN;
            cur_src_q <= target_w;
          end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      sys_tick_q <= 1'b0;
    end
    else
    begin
      sys_tick_q <= (sw_q == SW_RUN) && (target_w == cur_src_q)
                    && cur_tick_w;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      prim_off_q <= 1'b0;
    end
    else
    begin
      prim_off_q <= !primary_on_q && (cur_src_q != SRC_PRI);
    end
  end

  assign rd_data_o              = rd_data_q;
  assign sys_tick_o             = sys_tick_q;
  assign int_tick_o             = int_tick_q;
  assign wdt_tick_o             = wdt_tick_q;
  assign osc_tune_o             = osc_tune_field_q;
  assign pll_enable_o           = pll_enable_q;
  assign primary_osc_off_o      = prim_off_q;
  assign secondary_osc_enable_o = secondary_osc_enable_q;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  sequence drain_done_s;
    (sw_q == SW_DRAIN) && cur_tick_w;
  endsequence

  sequence arm_done_s;
    (sw_q == SW_ARM) && tgt_tick_w;
  endsequence

  reset_defaults_a: assert property ($fell(rst_i) |->
    sys_clk_select_q == SEL_RST && cur_src_q == SRC_PRI)
    else $error("select not primary after reset");

  reset_freq_a: assert property ($fell(rst_i) |->
    int_freq_select_q == FREQ_1M)
    else $error("internal output not 1 MHz after reset");

  select_write_a: assert property (wr_ctrl_w |=>
    sys_clk_select_q == $past(wr_data_i[1:0]))
    else $error("select field not written");

  switch_start_a: assert property
    ((sw_q == SW_RUN) && (target_w != cur_src_q) |=> sw_q == SW_DRAIN)
    else $error("handover did not start");

  switch_seq_a: assert property
    (drain_done_s ##[1:64] arm_done_s |=> cur_src_q == $past(target_w)
      && sw_q == SW_RUN)
    else $error("handover did not complete");

  glitch_hold_a: assert property ((sw_q != SW_RUN) |=> !sys_tick_q)
    else $error("main clock pulsed during handover");

  run_follow_a: assert property
    ((sw_q == SW_RUN) && (target_w == cur_src_q) && (cur_src_q == SRC_SEC)
      |=> sys_tick_q == $past(ticks_i.secondary))
    else $error("secondary not passed to main clock");

  full_speed_a: assert property
    ((int_freq_select_q == FREQ_16M) && ticks_i.hf |=> int_tick_q)
    else $error("high source not passed through");

  post_eight_a: assert property
    ((int_freq_select_q == FREQ_8M) && ticks_i.hf && !hf_div_q[0]
      |=> !int_tick_q)
    else $error("8 MHz postscale wrong");

  low_select_a: assert property
    ((int_freq_select_q == FREQ_31K) && !lowfreq_src_select_q
      |=> int_tick_q == $past(ticks_i.lf))
    else $error("low source not chosen at code 000");

  watchdog_feed_a: assert property
    (1'b1 |=> wdt_tick_q == $past(ticks_i.lf))
    else $error("watchdog feed not low oscillator");

  tune_write_a: assert property (wr_tune_w |=>
    osc_tune_o == $past(wr_data_i[5:0]) && pll_enable_o ==
    $past(wr_data_i[PLL_EN_BIT]))
    else $error("tuning register not written");

  status_read_a: assert property
    (rd_i && (addr_i == OSC_CONTROL2_OFS) |=>
      rd_data_o[PLL_LOCK_BIT] == $past(status_i.pll_locked)
      && rd_data_o[SEC_RUN_BIT] == $past(status_i.sec_running))
    else $error("status bits not reported");

endmodule : csel_top

/* File: csel_top_tb.sv */
module csel_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import csel_pkg::*;

  logic                     sys_clk_i;
  logic                     rst_i;
  logic [ADDR_W-1:0]        addr_i;
  logic [DATA_W-1:0]        wr_data_i;
  logic                     wr_i;
  logic                     rd_i;
  logic [DATA_W-1:0]        rd_data_o;
  logic [3:0]               primary_clk_config_i;
  csel_ticks_s              ticks_i;
  csel_status_s             status_i;
  logic                     sys_tick_o;
  logic                     int_tick_o;
  logic                     wdt_tick_o;
  logic [5:0]               osc_tune_o;
  logic                     pll_enable_o;
  logic                     primary_osc_off_o;
  logic                     secondary_osc_enable_o;
  int                       n_mismatch;
  int                       check_count;
  int                       c_sys;
  int                       c_int;
  int                       c_wdt;

  csel_top DUT (
    .sys_clk_i              (sys_clk_i),
    .rst_i                  (rst_i),
    .addr_i                 (addr_i),
    .wr_data_i              (wr_data_i),
    .wr_i                   (wr_i),
    .rd_i                   (rd_i),
    .rd_data_o              (rd_data_o),
    .primary_clk_config_i   (primary_clk_config_i),
    .ticks_i                (ticks_i),
    .status_i               (status_i),
    .sys_tick_o             (sys_tick_o),
    .int_tick_o             (int_tick_o),
    .wdt_tick_o             (wdt_tick_o),
    .osc_tune_o             (osc_tune_o),
    .pll_enable_o           (pll_enable_o),
    .primary_osc_off_o      (primary_osc_off_o),
    .secondary_osc_enable_o (secondary_osc_enable_o)
  );

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk_i = 1'b0;
    forever #4 sys_clk_i = ~sys_clk_i;
  end

  // Output pulses counted away from the rising edge
  always @(negedge sys_clk_i)
  begin
    c_sys = c_sys + int'(sys_tick_o);
    c_int = c_int + int'(int_tick_o);
    c_wdt = c_wdt + int'(wdt_tick_o);
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: %s got %h expected %h",
               $time, what, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    @(posedge sys_clk_i);
    addr_i    <= a;
    wr_data_i <= d;
    wr_i      <= 1'b1;
    @(posedge sys_clk_i);
    wr_i      <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] exp, input string what);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge sys_clk_i);
    rd_i   <= 1'b0;
    #1;
    chk(16'(rd_data_o), 16'(exp), what);
  endtask : rd_chk

  // Pulses the masked tick inputs n times, one idle cycle between
  task automatic tick(input logic [5:0] mask, input int n);
    c_sys = 0;
    c_int = 0;
    c_wdt = 0;
    repeat (n)
    begin
      @(posedge sys_clk_i);
      ticks_i <= mask;
      @(posedge sys_clk_i);
      ticks_i <= 6'h00;
    end
    repeat (3) @(posedge sys_clk_i);
  endtask : tick

  task automatic do_reset(input logic [3:0] cfg);
    @(posedge sys_clk_i);
    rst_i                <= 1'b1;
    primary_clk_config_i <= cfg;
    repeat (6) @(posedge sys_clk_i);
    rst_i                <= 1'b0;
  endtask : do_reset

  //////////////////////////////////////////////////////////////////////////
  localparam int NC = 12;
  localparam logic [2:0] C_FRQ [NC] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3,
    3'h2, 3'h2, 3'h1, 3'h1, 3'h0, 3'h0, 3'h0};
  localparam logic C_MFS [NC] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
    1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1};
  localparam logic C_LFS [NC] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0,
    1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
  localparam logic [5:0] C_MSK [NC] = '{6'h04, 6'h04, 6'h04, 6'h04,
    6'h04, 6'h04, 6'h02, 6'h04, 6'h02, 6'h01, 6'h05, 6'h02};
  localparam int C_N [NC] = '{64, 64, 64, 64, 64, 64, 64, 64, 64, 64,
    512, 64};
  localparam int C_EXP [NC] = '{64, 32, 16, 8, 4, 2, 64, 1, 32, 64, 1, 4};

  initial
  begin
    repeat (20000) @(posedge sys_clk_i);
    n_mismatch++;
    $display("unexpected at %0t: run timed out", $time);
    complete_run();
  end

  initial
  begin
    n_mismatch           = 0;
    check_count          = 0;
    rst_i                = 1'b1;
    addr_i               = '0;
    wr_data_i            = '0;
    wr_i                 = 1'b0;
    rd_i                 = 1'b0;
    primary_clk_config_i = 4'h0;
    ticks_i              = 6'h00;
    status_i             = 6'h2a;
    repeat (6) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    // Reset values, status and register access
    rd_chk(OSC_CONTROL_OFS, 8'h38, "ctrl reset");
    rd_chk(OSC_CONTROL2_OFS, 8'h46, "ctrl2 reset");
    rd_chk(OSC_TUNING_OFS, 8'h00, "tune reset");
    chk(16'(pll_enable_o), 16'h0, "pll reset");
    chk(16'(primary_osc_off_o), 16'h0, "pri off reset");
    @(posedge sys_clk_i);
    status_i <= 6'h15;
    rd_chk(OSC_CONTROL_OFS, 8'h34, "ctrl status");
    rd_chk(OSC_CONTROL2_OFS, 8'h85, "ctrl2 status");
    wr_reg(OSC_TUNING_OFS, 8'hff);
    wr_reg(2'h3, 8'h00);
    rd_chk(OSC_TUNING_OFS, 8'hff, "tune rw");
    rd_chk(2'h3, 8'h00, "unmapped");
    chk(16'(osc_tune_o), 16'h3f, "tune out");
    chk(16'(pll_enable_o), 16'h1, "pll enable");
    wr_reg(OSC_CONTROL2_OFS, 8'hff);
    rd_chk(OSC_CONTROL2_OFS, 8'h9d, "ctrl2 rw");
    chk(16'(secondary_osc_enable_o), 16'h1, "sec en");
    wr_reg(OSC_CONTROL_OFS, 8'hff);
    rd_chk(OSC_CONTROL_OFS, 8'h77, "ctrl rw");
    $display("test registers done");
    // Internal block frequency table
    for (int i = 0; i < NC; i++)
    begin
      wr_reg(OSC_CONTROL_OFS, {1'b0, C_FRQ[i], 4'h0});
      wr_reg(OSC_CONTROL2_OFS, {3'h0, C_MFS[i], 4'h4});
      wr_reg(OSC_TUNING_OFS, {C_LFS[i], 1'b0, 6'h2a});
      tick(C_MSK[i], C_N[i]);
      chk(16'(c_int), 16'(C_EXP[i]), "int ticks");
      chk(16'(c_wdt), C_MSK[i][0] ? 16'(C_N[i]) : 16'h0, "wdt");
    end
    chk(16'(osc_tune_o), 16'h2a, "tune value");
    $display("test frequency done");
    // Mid-run reset, then handover primary to secondary
    do_reset(4'h0);
    rd_chk(OSC_CONTROL_OFS, 8'h34, "ctrl rereset");
    tick(6'h20, 8);
    chk(16'(c_sys), 16'd8, "primary run");
    wr_reg(OSC_CONTROL_OFS, 8'h31);
    tick(6'h08, 8);
    chk(16'(c_sys), 16'd0, "held in drain");
    tick(6'h20, 1);
    chk(16'(c_sys), 16'd0, "held in arm");
    tick(6'h08, 8);
    chk(16'(c_sys), 16'd7, "secondary run");
    wr_reg(OSC_CONTROL2_OFS, 8'h00);
    @(posedge sys_clk_i);
    #1;
    chk(16'(primary_osc_off_o), 16'h1, "pri shut down");
    $display("test handover done");
    // Primary configured as internal block at default 1 MHz
    do_reset(CFG_INT_A);
    tick(6'h04, 16);
    chk(16'(c_int), 16'd1, "int default");
    chk(16'(c_sys), 16'd1, "primary internal");
    $display("test primary internal done");
    // Multiplier output replaces the primary tick when enabled
    do_reset(4'h0);
    wr_reg(OSC_TUNING_OFS, 8'h40);
    tick(6'h10, 4);
    chk(16'(c_sys), 16'd4, "pll run");
    tick(6'h20, 4);
    chk(16'(c_sys), 16'd0, "primary bypassed");
    $display("test multiplier done");
    complete_run();
  end

endmodule : csel_top_tb
